// File: core/timer8_pkg.sv
// constants shared by the four-channel 8-bit timer status, compare and capture logic
package timer8_pkg;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 8;

  // word index inside one channel window, channel in address bits 6:5
  localparam logic [2:0] IDX_CTRL    = 3'h0;
  localparam logic [2:0] IDX_CSR     = 3'h1;
  localparam logic [2:0] IDX_CONST_A = 3'h2;
  localparam logic [2:0] IDX_CONST_B = 3'h3;
  localparam logic [2:0] IDX_COUNT   = 3'h4;
  localparam int IDX_LSB  = 2;
  localparam int CH_LSB   = 5;
  localparam int SPACE_BIT = 7;

  // control/status field positions
  localparam int CSR_B_FLAG    = 7;
  localparam int CSR_A_FLAG    = 6;
  localparam int CSR_WRAP_FLAG = 5;
  localparam int CSR_MODE_BIT  = 4;
  // channel control field positions
  localparam int CTRL_B_IRQ_EN    = 7;
  localparam int CTRL_A_IRQ_EN    = 6;
  localparam int CTRL_WRAP_IRQ_EN = 5;

  localparam logic [7:0] CSR_RESET     = 8'h00;
  localparam logic [7:0] CSR_RESET_CH2 = 8'h10;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] CONST_RESET   = 8'hFF;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] COUNT_MAX     = 8'hFF;
  localparam logic [2:0] FLAG_MASK     = 3'h7;

  // clock select codes
  localparam logic [2:0] CKS_OFF      = 3'h0;
  localparam logic [2:0] CKS_DIV8     = 3'h1;
  localparam logic [2:0] CKS_DIV64    = 3'h2;
  localparam logic [2:0] CKS_DIV8192  = 3'h3;
  localparam logic [2:0] CKS_CASCADE  = 3'h4;
  localparam logic [2:0] CKS_EXT_RISE = 3'h5;
  localparam logic [2:0] CKS_EXT_FALL = 3'h6;
  localparam logic [2:0] CKS_EXT_BOTH = 3'h7;

  // counter clear sources
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_A    = 2'h1;
  localparam logic [1:0] CLR_B    = 2'h2;
  localparam logic [1:0] CLR_CAPT = 2'h3;

  // capture edge codes and output actions (action code order is its priority)
  localparam logic [1:0] EDGE_RISE  = 2'h0;
  localparam logic [1:0] EDGE_FALL  = 2'h1;
  localparam logic [1:0] EDGE_BOTH  = 2'h2;
  localparam logic [1:0] ACT_KEEP   = 2'h0;
  localparam logic [1:0] ACT_ZERO   = 2'h1;
  localparam logic [1:0] ACT_ONE    = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  localparam int PRE_W = 13;
  localparam logic [PRE_W-1:0] DIV8_MASK    = 13'h0007;
  localparam logic [PRE_W-1:0] DIV64_MASK   = 13'h003F;
  localparam logic [PRE_W-1:0] DIV8192_MASK = 13'h1FFF;
endpackage

// File: core/timer8_pin_out.sv
// compare-match output pin driver of one timer channel
`timescale 1ns/100ps
`default_nettype none
module timer8_pin_out (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic       i_standby,
  input  wire logic       i_match_a,
  input  wire logic       i_match_b,
  input  wire logic       i_b_compare_on,
  input  wire logic       i_pin_is_input,
  input  wire logic [1:0] i_a_sel,
  input  wire logic [1:0] i_b_sel,
  output logic            o_level,
  output logic            o_enable
);
  import timer8_pkg::*;

  logic       level_q;
  logic       level_d;
  logic [1:0] act_a;
  logic [1:0] act_b;
  logic [1:0] act;

  assign act_a = i_match_a ? i_a_sel : ACT_KEEP;
  // compare B is silenced while the pair captures
  assign act_b = (i_match_b && i_b_compare_on) ? i_b_sel : ACT_KEEP;
  // codes are ordered by priority, so the larger one wins
  assign act = (act_a > act_b) ? act_a : act_b;

  always_comb begin
    case (act)
      ACT_ZERO:   level_d = 1'b0;
      ACT_ONE:    level_d = 1'b1;
      ACT_TOGGLE: level_d = ~level_q;
      default:    level_d = level_q;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level_q <= 1'b0;
    end else if (i_standby) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level_d;
    end
  end

  assign o_level  = level_q;
  assign o_enable = ~i_pin_is_input && (|{i_a_sel, i_b_sel});
endmodule
`default_nettype wire

// File: core/timer8_core.sv
// four-channel 8-bit timer: counters, compare, capture, status flags, wishbone registers
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module timer8_core (
  input  wire logic                             i_clk_sys,
  input  wire logic                             i_rst_n,
  input  wire logic                             i_standby,
  input  wire logic                             i_wb_cyc,
  input  wire logic                             i_wb_stb,
  input  wire logic                             i_wb_we,
  input  wire logic [timer8_pkg::ADDR_W-1:0]    i_wb_adr,
  input  wire logic [31:0]                      i_wb_dat,
  input  wire logic [3:0]                       i_wb_sel,
  output logic [31:0]                           o_wb_dat,
  output logic                                  o_wb_ack,
  input  wire logic [timer8_pkg::NUM_CH-1:0]    i_ext_clk,
  input  wire logic [1:0]                       i_odd_channel_io_pin_in,
  input  wire logic                             i_converter_ext_trigger_enable,
  input  wire logic                             i_converter_trigger_pin,
  output logic                                  o_converter_start,
  output logic [timer8_pkg::NUM_CH-1:0]         o_timer_out,
  output logic [timer8_pkg::NUM_CH-1:0]         o_timer_oe,
  output logic [timer8_pkg::NUM_CH-1:0]         o_match_a_irq,
  output logic [timer8_pkg::NUM_CH-1:0]         o_match_b_irq,
  output logic [timer8_pkg::NUM_CH-1:0]         o_wrap_irq
);
  import timer8_pkg::*;
  function automatic logic masked_tick(input logic [PRE_W-1:0] pre,
                                       input logic [PRE_W-1:0] mask);
    masked_tick = ((pre & mask) == mask);
  endfunction

  function automatic logic edge_hit(input logic [1:0] code,
                                    input logic       rise,
                                    input logic       fall);
    case (code)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default:   edge_hit = 1'b0;
    endcase
  endfunction
  // bus slave
  logic              ack_q;
  logic [31:0]       rdat_q;
  logic              bus_acc;
  logic              bus_wr;
  logic              bus_rd;
  logic [1:0]        bus_ch;
  logic [2:0]        bus_idx;
  logic              bus_mapped;
  logic [7:0]        bus_wbyte;
  logic [7:0]        rd_byte;

  assign bus_acc    = i_wb_cyc && i_wb_stb && !ack_q;
  assign bus_ch     = i_wb_adr[CH_LSB +: 2];
  assign bus_idx    = i_wb_adr[IDX_LSB +: 3];
  assign bus_mapped = !i_wb_adr[SPACE_BIT] && (bus_idx <= IDX_COUNT);
  assign bus_wr     = bus_acc && i_wb_we && i_wb_sel[0] && bus_mapped;
  assign bus_rd     = bus_acc && !i_wb_we && bus_mapped;
  assign bus_wbyte  = i_wb_dat[7:0];
  // prescaler and shared edge detectors
  logic [PRE_W-1:0]  pre_q;
  logic [NUM_CH-1:0] ext_prev_q;
  logic [1:0]        cap_prev_q;
  logic              trig_prev_q;
  logic              start_q;
  logic              tick8;
  logic              tick64;
  logic              tick8192;

  assign tick8    = masked_tick(pre_q, DIV8_MASK);
  assign tick64   = masked_tick(pre_q, DIV64_MASK);
  assign tick8192 = masked_tick(pre_q, DIV8192_MASK);
  // per-channel results gathered for pairing and readback
  logic [7:0]        ctrl_v    [NUM_CH];
  logic [7:0]        csr_v     [NUM_CH];
  logic [7:0]        const_a_v [NUM_CH];
  logic [7:0]        const_b_v [NUM_CH];
  logic [7:0]        cnt_v     [NUM_CH];
  logic [NUM_CH-1:0] wrap_evt_q;
  logic [NUM_CH-1:0] match_a_evt_q;
  logic [NUM_CH-1:0] match_a_now;
  logic [NUM_CH-1:0] mode_bit;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    localparam bit ODD = (ch % 2) == 1;
    localparam int PARTNER = ODD ? ch - 1 : ch + 1;
    localparam logic [7:0] CSR_INIT = (ch == 2) ? CSR_RESET_CH2 : CSR_RESET;
    localparam logic [1:0] CH_ID = 2'(ch);
    logic [7:0] ctrl_q;
    logic [7:0] cnt_q;
    logic [7:0] const_a_q;
    logic [7:0] const_b_q;
    logic [2:0] flag_q;
    logic [2:0] armed_q;
    logic [4:0] low_q;
    logic       wrap_evt_r;
    logic       match_a_evt_r;
    logic       sel_me;
    logic       wr_ctrl;
    logic       wr_csr;
    logic       wr_a;
    logic       wr_b;
    logic       wr_cnt;
    logic       rd_csr;
    logic [2:0] cks;
    logic [1:0] clr_sel;
    logic       rise;
    logic       fall;
    logic       cascade_evt;
    logic       tick;
    logic       cap_mode;
    logic       b_blocked;
    logic       capture;
    logic       match_a;
    logic       match_b_cmp;
    logic       match_b;
    logic       wrap;
    logic       clr_evt;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic [2:0] flag_d;
    logic [7:0] cnt_d;
    logic [4:0] low_d;
    assign sel_me  = (bus_ch == CH_ID);
    assign wr_ctrl = bus_wr && sel_me && (bus_idx == IDX_CTRL);
    assign wr_csr  = bus_wr && sel_me && (bus_idx == IDX_CSR);
    assign wr_a    = bus_wr && sel_me && (bus_idx == IDX_CONST_A);
    assign wr_b    = bus_wr && sel_me && (bus_idx == IDX_CONST_B);
    assign wr_cnt  = bus_wr && sel_me && (bus_idx == IDX_COUNT);
    assign rd_csr  = bus_rd && sel_me && (bus_idx == IDX_CSR);
    assign cks     = ctrl_q[2:0];
    assign clr_sel = ctrl_q[4:3];
    assign rise    = i_ext_clk[ch] && !ext_prev_q[ch];
    assign fall    = !i_ext_clk[ch] && ext_prev_q[ch];
    // partner events come from flops so a forbidden cascade loop stays acyclic
    assign cascade_evt = ODD ? match_a_evt_q[PARTNER] : wrap_evt_q[PARTNER];
    always_comb begin
      case (cks)
        CKS_OFF:      tick = 1'b0;
        CKS_DIV8:     tick = tick8;
        CKS_DIV64:    tick = tick64;
        CKS_DIV8192:  tick = tick8192;
        CKS_CASCADE:  tick = cascade_evt;
        CKS_EXT_RISE: tick = rise;
        CKS_EXT_FALL: tick = fall;
        CKS_EXT_BOTH: tick = rise | fall;
        default:      tick = 1'b0;
      endcase
    end
    if (ODD) begin : g_odd
      logic pin_rise;
      logic pin_fall;
      assign pin_rise  = i_odd_channel_io_pin_in[ch/2] && !cap_prev_q[ch/2];
      assign pin_fall  = !i_odd_channel_io_pin_in[ch/2] && cap_prev_q[ch/2];
      assign cap_mode  = low_q[CSR_MODE_BIT];
      assign b_blocked = 1'b0;
      assign capture   = cap_mode && edge_hit(low_q[3:2], pin_rise, pin_fall);
    end else begin : g_even
      assign cap_mode  = 1'b0;
      assign b_blocked = mode_bit[PARTNER];
      assign capture   = 1'b0;
    end
    // a match is taken as the matched count is left, i.e. on the counting pulse
    assign match_a     = tick && (cnt_q == const_a_q);
    assign match_b_cmp = tick && (cnt_q == const_b_q) && !cap_mode;
    assign match_b     = capture || (match_b_cmp && !b_blocked);
    assign wrap        = tick && (cnt_q == COUNT_MAX);
    assign clr_evt = ((clr_sel == CLR_A) && match_a) ||
                     ((clr_sel == CLR_B) && match_b) ||
                     ((clr_sel == CLR_CAPT) && capture);
    always_comb begin
      if (wr_cnt) begin
        cnt_d = bus_wbyte;
      end else if (clr_evt) begin
        cnt_d = COUNT_RESET;
      end else if (tick) begin
        cnt_d = cnt_q + 8'h01;
      end else begin
        cnt_d = cnt_q;
      end
    end
    assign flag_set = {match_b, match_a, wrap};
    // only zeros clear, and only flags seen as one by an earlier read
    assign flag_clr = wr_csr ? (armed_q & ~bus_wbyte[7:5]) : 3'h0;
    assign flag_d   = flag_set | (flag_q & ~flag_clr);
    // channel 2 bit 4 has no function and keeps its reset value
    assign low_d = (ch == 2) ? {CSR_INIT[4], bus_wbyte[3:0]} : bus_wbyte[4:0];

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
        ctrl_q    <= CTRL_RESET;
        cnt_q     <= COUNT_RESET;
        const_a_q <= CONST_RESET;
        const_b_q <= CONST_RESET;
      end else if (i_standby) begin
        ctrl_q    <= CTRL_RESET;
        cnt_q     <= COUNT_RESET;
        const_a_q <= CONST_RESET;
        const_b_q <= CONST_RESET;
      end else begin
        if (wr_ctrl) begin
          ctrl_q <= bus_wbyte;
        end
        if (wr_a) begin
          const_a_q <= bus_wbyte;
        end
        // a capture overrides a software write in the same cycle
        if (capture) begin
          const_b_q <= cnt_q;
        end else if (wr_b) begin
          const_b_q <= bus_wbyte;
        end
        cnt_q <= cnt_d;
      end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
        flag_q  <= CSR_INIT[7:5];
        low_q   <= CSR_INIT[4:0];
        armed_q <= 3'h0;
      end else if (i_standby) begin
        flag_q  <= CSR_INIT[7:5];
        low_q   <= CSR_INIT[4:0];
        armed_q <= 3'h0;
      end else begin
        flag_q <= flag_d;
        if (wr_csr) begin
          low_q <= low_d;
        end
        if (rd_csr) begin
          armed_q <= flag_q;
        end else if (wr_csr) begin
          armed_q <= 3'h0;
        end
      end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
        wrap_evt_r    <= 1'b0;
        match_a_evt_r <= 1'b0;
      end else begin
        wrap_evt_r    <= wrap;
        match_a_evt_r <= match_a;
      end
    end

    assign wrap_evt_q[ch]    = wrap_evt_r;
    assign match_a_evt_q[ch] = match_a_evt_r;
    assign match_a_now[ch]   = match_a;
    assign mode_bit[ch]      = low_q[CSR_MODE_BIT];
    assign ctrl_v[ch]        = ctrl_q;
    assign csr_v[ch]         = {flag_q, low_q};
    assign const_a_v[ch]     = const_a_q;
    assign const_b_v[ch]     = const_b_q;
    assign cnt_v[ch]         = cnt_q;

    // requests follow the flags, so a blocked even B match raises none
    assign o_match_b_irq[ch] = flag_q[2] && ctrl_q[CTRL_B_IRQ_EN];
    assign o_match_a_irq[ch] = flag_q[1] && ctrl_q[CTRL_A_IRQ_EN];
    assign o_wrap_irq[ch]    = flag_q[0] && ctrl_q[CTRL_WRAP_IRQ_EN];

    timer8_pin_out u_pin (
      .i_clk_sys      (i_clk_sys),
      .i_rst_n        (i_rst_n),
      .i_standby      (i_standby),
      .i_match_a      (match_a),
      .i_match_b      (match_b_cmp),
      .i_b_compare_on (!b_blocked),
      .i_pin_is_input (cap_mode),
      .i_a_sel        (low_q[1:0]),
      .i_b_sel        (low_q[3:2]),
      .o_level        (o_timer_out[ch]),
      .o_enable       (o_timer_oe[ch])
    );
  end

  logic [7:0] rd_sel_ctrl;
  logic [7:0] rd_sel_csr;
  logic [7:0] rd_sel_a;
  logic [7:0] rd_sel_b;
  logic [7:0] rd_sel_cnt;
  assign rd_sel_ctrl = ctrl_v[bus_ch];
  assign rd_sel_csr  = csr_v[bus_ch];
  assign rd_sel_a    = const_a_v[bus_ch];
  assign rd_sel_b    = const_b_v[bus_ch];
  assign rd_sel_cnt  = cnt_v[bus_ch];

  always_comb begin
    case (bus_idx)
      IDX_CTRL:    rd_byte = rd_sel_ctrl;
      IDX_CSR:     rd_byte = rd_sel_csr;
      IDX_CONST_A: rd_byte = rd_sel_a;
      IDX_CONST_B: rd_byte = rd_sel_b;
      IDX_COUNT:   rd_byte = rd_sel_cnt;
      default:     rd_byte = 8'h00;
    endcase
  end

  // unmapped reads still get an ack, with zero data
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= bus_acc;
      rdat_q <= bus_rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  logic trig_rise;
  logic start_d;

  assign trig_rise = i_converter_trigger_pin && !trig_prev_q;
  assign start_d   = i_converter_ext_trigger_enable &&
                     (mode_bit[0] ? match_a_now[0] : trig_rise);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_q       <= '0;
      ext_prev_q  <= '0;
      cap_prev_q  <= 2'h0;
      trig_prev_q <= 1'b0;
      start_q     <= 1'b0;
    end else begin
      pre_q       <= pre_q + PRE_W'(1);
      ext_prev_q  <= i_ext_clk;
      cap_prev_q  <= i_odd_channel_io_pin_in;
      trig_prev_q <= i_converter_trigger_pin;
      start_q     <= start_d;
    end
  end

  assign o_converter_start = start_q;
endmodule
`default_nettype wire

// File: testbench/timer8_core_sva.sv
// concurrent checks on the timer's bus, converter, pin and request ports
`timescale 1ns/100ps
`default_nettype none
module timer8_core_sva (
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  input wire logic        i_standby,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        i_converter_ext_trigger_enable,
  input wire logic        o_converter_start,
  input wire logic [3:0]  o_timer_out,
  input wire logic [3:0]  o_timer_oe,
  input wire logic [3:0]  o_match_a_irq,
  input wire logic [3:0]  o_match_b_irq,
  input wire logic [3:0]  o_wrap_irq
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  logic [11:0] irq_v;
  logic        wr_ack;
  assign irq_v = {o_match_a_irq, o_match_b_irq, o_wrap_irq};
  assign wr_ack = o_wb_ack && i_wb_we;
  ack_resp_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus request not answered next cycle");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  ack_idle_a: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
    else $error("ack without request");
  rdat_high_a: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h00_0000)
    else $error("read data upper bytes not zero");
  rdat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
    else $error("read data driven outside ack");
  conv_gate_a: assert property (o_converter_start |-> $past(i_converter_ext_trigger_enable))
    else $error("converter start while trigger disabled");
  oe_write_a: assert property (!$stable(o_timer_oe) |-> wr_ack || $past(i_standby))
    else $error("output enable moved without register write");
  irq_fall_a: assert property (|($past(irq_v) & ~irq_v) |-> wr_ack || $past(i_standby))
    else $error("request dropped without a write");
  init_quiet_a: assert property (!$past(i_rst_n) || $past(i_standby)
    |-> o_timer_oe == 4'h0 && o_timer_out == 4'h0 && irq_v == 12'h000)
    else $error("outputs not at initial values after init");
endmodule
bind timer8_core timer8_core_sva chk (.i_clk_sys, .i_rst_n, .i_standby, .i_wb_cyc,
  .i_wb_stb, .i_wb_we, .o_wb_dat, .o_wb_ack, .i_converter_ext_trigger_enable,
  .o_converter_start, .o_timer_out, .o_timer_oe, .o_match_a_irq, .o_match_b_irq,
  .o_wrap_irq);
`default_nettype wire

// File: testbench/timer8_pin_model.sv
// pin-side model: free-running count clocks, capture input and converter trigger
`timescale 1ns/100ps
`default_nettype none
module timer8_pin_model (
  input  wire logic       i_clk_sys,
  input  wire logic [1:0] i_cap_lvl,
  input  wire logic       i_trig_go,
  output logic [3:0]      o_ext_clk,
  output logic [1:0]      o_cap_pin,
  output logic            o_trig_pin
);
  logic [1:0] div_q;
  logic [2:0] trig_q;
  initial begin
    div_q = 2'h0;
    trig_q = 3'h0;
    o_ext_clk = 4'h0;
    o_cap_pin = 2'h0;
    o_trig_pin = 1'b0;
  end
  // three-cycle half period keeps both-edge pulses wider than 2.5 clocks
  always @(posedge i_clk_sys) begin
    div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
    if (div_q == 2'h2) o_ext_clk <= ~o_ext_clk;
    o_cap_pin <= i_cap_lvl;
    trig_q <= {trig_q[1:0], i_trig_go};
    o_trig_pin <= |trig_q;
  end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the four-channel timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %0t got %0h exp %0h", $time, g, e); end end
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        standby = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic        chk_r = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] seed = 32'h0000_5310;
  logic [31:0] rdat, e;
  logic [31:0] expq[$];
  logic [7:0]  v, last_rd;
  logic [7:0]  outs [4] = '{8'h03, 8'h0D, 8'h01, 8'h09};
  int          lvl [4] = '{2, 2, 0, 1};
  logic        conv_en = 1'b0;
  logic        trig_go = 1'b0;
  logic        tout_q = 1'b0;
  logic        ack, conv_start, trig_pin;
  logic [1:0]  cap_lvl = 2'h0;
  logic [1:0]  cap_pin;
  logic [3:0]  ext_clk, tout, toe, a_irq, b_irq, w_irq;
  int          error_cnt = 0, comparisons = 0, nstart = 0, ntog = 0, tg;

  timer8_core dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_standby(standby), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_ext_clk(ext_clk), .i_odd_channel_io_pin_in(cap_pin),
    .i_converter_ext_trigger_enable(conv_en), .i_converter_trigger_pin(trig_pin),
    .o_converter_start(conv_start), .o_timer_out(tout), .o_timer_oe(toe),
    .o_match_a_irq(a_irq), .o_match_b_irq(b_irq), .o_wrap_irq(w_irq));
  timer8_pin_model pins (.i_clk_sys(clk), .i_cap_lvl(cap_lvl), .i_trig_go(trig_go),
    .o_ext_clk(ext_clk), .o_cap_pin(cap_pin), .o_trig_pin(trig_pin));

  initial forever #4 clk = ~clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic c);
    if (c) expq.push_back({24'h00_0000, d});
    @(posedge clk);
    {cyc, stb, we, chk_r} <= {2'b11, w, c};
    sel <= 4'h1;
    adr <= a;
    wdat <= {24'h00_0000, d};
    // no wait-state count is assumed: only the watchdog ends a hung access
    do @(posedge clk); while (ack !== 1'b1);
    last_rd = rdat[7:0];
    {cyc, stb, we} <= 3'b000;
    sel <= 4'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d); bus(a, 1'b1, d, 1'b0); endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x); bus(a, 1'b0, x, 1'b1); endtask
  task automatic wait_n(input int n); repeat (n) @(posedge clk); endtask

  task automatic finish_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // read results are compared against the oldest note as the ack appears
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && chk_r === 1'b1 && expq.size() > 0) begin
      e = expq.pop_front();
      `CHK(rdat, e)
    end
    ntog <= ntog + int'(tout[0] !== tout_q);
    tout_q <= tout[0];
    nstart <= nstart + int'(conv_start === 1'b1);
  end

  initial begin
    fork
      begin
        #(8 * 20000);
        error_cnt++;
        finish_test();
      end
    join_none
    wait_n(20);
    rst_n <= 1'b1;
    rd(8'h04, 8'h00);
    rd(8'h24, 8'h00);
    rd(8'h44, 8'h10);
    rd(8'h64, 8'h00);
    wr(8'h04, 8'hE0);
    rd(8'h04, 8'h00);
    wr(8'h44, 8'h00);
    rd(8'h44, 8'h10);
    wr(8'h80, 8'h55);
    rd(8'h80, 8'h00);
    rd(8'h14, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'(xs());
      wr(8'(i * 32 + 12), v);
      rd(8'(i * 32 + 12), v);
    end
    // counter near the top so A, B and wrap all occur within a few /8 ticks
    wr(8'h10, 8'hFD);
    wr(8'h08, 8'hFE);
    wr(8'h0C, 8'hFF);
    wr(8'h00, 8'hE1);
    wait_n(80);
    wr(8'h00, 8'hE0);
    `CHK({b_irq[0], a_irq[0], w_irq[0]}, 3'b111)
    wr(8'h00, 8'h00);
    `CHK({b_irq[0], a_irq[0], w_irq[0]}, 3'b000)
    wr(8'h04, 8'h00);
    rd(8'h04, 8'hE0);
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h00);
    // A and B match together every other tick, counter cleared by A
    wr(8'h10, 8'h00);
    wr(8'h08, 8'h01);
    wr(8'h0C, 8'h01);
    wr(8'h00, 8'h09);
    for (int k = 0; k < 4; k++) begin
      wr(8'h04, outs[k]);
      tg = ntog;
      wait_n(96);
      if (lvl[k] == 2) `CHK(ntog - tg > 3, 1'b1)
      else `CHK(tout[0], lvl[k][0])
      `CHK(toe[0], 1'b1)
    end
    wr(8'h04, 8'h00);
    `CHK(toe[0], 1'b0)
    conv_en <= 1'b1;
    wr(8'h04, 8'h10);
    tg = nstart;
    wait_n(64);
    `CHK(nstart - tg > 2, 1'b1)
    wr(8'h04, 8'h00);
    for (int k = 0; k < 2; k++) begin
      conv_en <= (k == 0);
      tg = nstart;
      trig_go <= 1'b1;
      @(posedge clk);
      trig_go <= 1'b0;
      wait_n(20);
      `CHK(nstart - tg, (k == 0) ? 1 : 0)
    end
    wr(8'h20, 8'h01);
    wr(8'h24, 8'h10);
    wait_n(20);
    bus(8'h04, 1'b0, 8'h00, 1'b0);
    wr(8'h04, 8'h00);
    for (int c = 0; c < 4; c++) begin
      v = 8'h13 | (8'(c) << 2);
      wr(8'h24, v);
      `CHK(toe[1], 1'b0)
      cap_lvl <= 2'h1;
      wait_n(8);
      cap_lvl <= 2'h0;
      wait_n(8);
      rd(8'h24, (c == 3) ? v : (v | 8'h80));
      wr(8'h24, v);
    end
    rd(8'h04, 8'h40);
    // ch1 counts ch0 compare-A while ch0 runs from the prescaler, never the loop
    wr(8'h30, 8'h00);
    wr(8'h20, 8'h04);
    wait_n(64);
    wr(8'h20, 8'h00);
    bus(8'h30, 1'b0, 8'h00, 1'b0);
    `CHK(last_rd > 8'h02 && last_rd < 8'h07, 1'b1)
    for (int m = 5; m < 8; m++) begin
      wr(8'h70, 8'h00);
      wr(8'h60, 8'(m));
      wait_n(60);
      wr(8'h60, 8'h00);
      bus(8'h70, 1'b0, 8'h00, 1'b0);
      if (m == 7) `CHK(last_rd > 8'h10 && last_rd < 8'h1A, 1'b1)
      else `CHK(last_rd > 8'h08 && last_rd < 8'h0D, 1'b1)
    end
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    rd(8'h24, 8'h00);
    rd(8'h44, 8'h10);
    rd(8'h20, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
